/* File: common/cah_chan_if.sv */
// Purpose: channel tag and bus lines between channel and adapter
// Assumes: single clock, all lines synchronous
// Notes: no clocking block
`timescale 1ns/1ns
interface cah_chan_if;
    logic [7:0] bus_out;
    logic [7:0] bus_in;
    logic address_out;
    logic command_out;
    logic service_out;
    logic select_out;
    logic operational_out;
    logic general_reset;
    logic address_in;
    logic status_in;
    logic service_in;
    logic operational_in;
    logic request_in;
    // device end of the link
    modport adapter (
        input bus_out, address_out, command_out, service_out, select_out, operational_out, general_reset,
        output bus_in, address_in, status_in, service_in, operational_in, request_in
    );
    // channel end of the link
    modport channel (
        output bus_out, address_out, command_out, service_out, select_out, operational_out, general_reset,
        input bus_in, address_in, status_in, service_in, operational_in, request_in
    );
endinterface : cah_chan_if

/* File: common/cah_params.svh */
// Purpose: constants for the console adapter control, halt and reset logic
// Assumes: 8-bit channel bytes, bit 0 is the most significant bit of a byte
// Notes: status bit n sits at vector index 7-n
`ifndef CAH_PARAMS_SVH
`define CAH_PARAMS_SVH
`define CAH_ST_ATTN 7
`define CAH_ST_BUSY 4
`define CAH_ST_CE 3
`define CAH_ST_DE 2
`define CAH_ST_CHECK 1
`define CAH_CMD_ALARM_BIT 3
`define CAH_ADDR_OFF 8'h00
`define CAH_REG_CMD 8'h00
`define CAH_REG_STAT 8'h04
`define CAH_REG_IRQ 8'h08
`define CAH_REG_MASK 8'h0C
`define CAH_REG_TOGGLES 8'h10
`define CAH_DEV_ADDR 8'h1F
`define CAH_CMD_CTRL_MASK 8'h03
`define CAH_CMD_CTRL_VAL 8'h03
`define CAH_CMD_TIO 8'h00
`define CAH_CMD_SENSE 8'h04
`endif

/* File: common/cah_pkg.sv */
// Purpose: shared types of the console adapter control logic
// Assumes: included constants header
// Notes: command classes decoded from the channel command byte
package cah_pkg;
    typedef enum logic [1:0] {
        CAH_CMD_NONE = 2'b00,
        CAH_CMD_CTRL = 2'b01,
        CAH_CMD_TIO = 2'b10,
        CAH_CMD_OTHER = 2'b11
    } cah_cmd_t;
endpackage : cah_pkg

/* File: rtl/cah_adapter.sv */
// Purpose: adapter end: control commands, status interrogation, halt, resets
// Assumes: channel follows the tag protocol; inputs synchronous to aclk
// Notes: read/write data transfer is outside; io_busy and pending inputs come from it
`timescale 1ns/1ns
`include "cah_params.svh"
module cah_adapter
    import cah_pkg::*;
#(
    parameter logic [7:0] DEV_ADDR = `CAH_DEV_ADDR
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    cah_chan_if.adapter chan,
    input wire logic io_busy,
    input wire logic attn_event,
    output logic initial_reset,
    output logic sense_clear,
    output logic stop_reg,
    output logic [7:0] last_status_reg
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b010,
        ST_STAT = 3'b011,
        ST_WAIT = 3'b100,
        ST_INT = 3'b101
    } cah_st_t;
    cah_st_t state_reg;
    cah_cmd_t cls;
    logic alarm;
    logic op_in_reg, ce_reg, de_reg, busy_reg, attn_reg, tio_reg, stacked_reg;
    logic svc_req_reg, svc_in_reg, init_sel_reg;
    logic halt, sel_reset, rst_all, disconnect, accept;
    logic [7:0] status_byte;

    cah_cmd_decode u_dec (
        .cmd_byte(chan.bus_out),
        .cmd_class(cls),
        .is_alarm(alarm)
    );

    assign halt = op_in_reg && chan.address_out && !chan.select_out;
    assign sel_reset = op_in_reg && !chan.operational_out;
    assign rst_all = !aresetn || chan.general_reset || sel_reset;
    assign disconnect = rst_all || halt;
    assign accept = chan.status_in && chan.service_out;

    // status byte assembly
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`CAH_ST_ATTN] = attn_reg;
        // end bits at 4 and 5
        status_byte[`CAH_ST_CE] = ce_reg;
        status_byte[`CAH_ST_DE] = de_reg;
        status_byte[`CAH_ST_BUSY] = busy_reg && !(tio_reg && (attn_reg || ce_reg || de_reg || stacked_reg));
    end

    // connection sequence
    always_ff @(posedge aclk)
    begin
        if (disconnect)
        begin
            state_reg <= ST_IDLE;
            op_in_reg <= 1'b0;
            init_sel_reg <= 1'b0;
        end
        else if (ce)
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (chan.select_out && chan.address_out && chan.bus_out == DEV_ADDR)
                    begin
                        state_reg <= ST_ADDR;
                        op_in_reg <= 1'b1;
                        init_sel_reg <= 1'b1;
                    end
                    else if (chan.select_out && (ce_reg || attn_reg))
                    begin
                        state_reg <= ST_INT;
                        op_in_reg <= 1'b1;
                    end
                end
                ST_ADDR:
                    if (!chan.address_out)
                        state_reg <= ST_CMD;
                ST_CMD:
                    if (chan.command_out)
                        state_reg <= ST_STAT;
                ST_STAT:
                    if (!chan.command_out)
                        state_reg <= ST_WAIT;
                ST_WAIT, ST_INT:
                    if (accept)
                    begin
                        state_reg <= ST_IDLE;
                        op_in_reg <= 1'b0;
                        init_sel_reg <= 1'b0;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // end, busy and stop latches
    always_ff @(posedge aclk)
    begin
        if (rst_all)
        begin
            ce_reg <= 1'b0;
            de_reg <= 1'b0;
            busy_reg <= 1'b0;
            stop_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (accept)
            begin
                ce_reg <= 1'b0;
                de_reg <= 1'b0;
                busy_reg <= 1'b0;
            end
            if (tio_reg && accept)
                stop_reg <= 1'b0;
            if (state_reg == ST_CMD && chan.command_out && cls == CAH_CMD_CTRL)
            begin
                ce_reg <= 1'b1;
                de_reg <= 1'b1;
            end
            if (state_reg == ST_IDLE && chan.select_out && chan.address_out && chan.bus_out == DEV_ADDR && io_busy)
                busy_reg <= 1'b1;
            // halt sets stop, busy, channel end
            if (halt)
            begin
                stop_reg <= 1'b1;
                busy_reg <= 1'b1;
                ce_reg <= 1'b1;
            end
        end
    end

    // interrogation, attention and stacked latches
    always_ff @(posedge aclk)
    begin
        if (rst_all)
        begin
            tio_reg <= 1'b0;
            attn_reg <= 1'b0;
            stacked_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (state_reg == ST_CMD && chan.command_out && cls == CAH_CMD_TIO)
                tio_reg <= 1'b1;
            else if (!init_sel_reg)
                tio_reg <= 1'b0;
            // clear pending on accept, event wins
            if (attn_event)
                attn_reg <= 1'b1;
            else if (accept)
                attn_reg <= 1'b0;
            if (ce_reg && halt)
                stacked_reg <= 1'b1;
            else if (accept)
                stacked_reg <= 1'b0;
        end
    end

    // service triggers cleared on disconnect
    always_ff @(posedge aclk)
    begin
        if (disconnect)
        begin
            svc_req_reg <= 1'b0;
            svc_in_reg <= 1'b0;
        end
        else if (ce)
        begin
            svc_req_reg <= 1'b0;
            svc_in_reg <= 1'b0;
        end
    end

    // captured status and alarm pulses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_status_reg <= 8'h00;
            initial_reset <= 1'b0;
            sense_clear <= 1'b0;
        end
        else if (ce)
        begin
            if (state_reg == ST_STAT || state_reg == ST_INT)
                last_status_reg <= status_byte;
            initial_reset <= state_reg == ST_CMD && chan.command_out && cls == CAH_CMD_CTRL && alarm;
            sense_clear <= state_reg == ST_CMD && chan.command_out && cls == CAH_CMD_CTRL && alarm;
        end
    end

    // tag outputs
    assign chan.operational_in = op_in_reg;
    assign chan.address_in = state_reg == ST_CMD;
    assign chan.status_in = state_reg == ST_WAIT || state_reg == ST_INT;
    assign chan.service_in = svc_in_reg;
    assign chan.request_in = (ce_reg || attn_reg || svc_req_reg) && !op_in_reg;
    assign chan.bus_in = chan.status_in ? status_byte : (chan.address_in ? DEV_ADDR : 8'h00);
endmodule : cah_adapter

/* File: rtl/cah_channel.sv */
// Purpose: channel end: issues commands, halt, resets; reports over AXI4-Lite
// Assumes: one adapter attached
// Notes: command register write starts a selection when idle, except test I/O while op-in is up (busy from unit word)
`timescale 1ns/1ns
`include "cah_params.svh"
module cah_channel
    import cah_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    cah_chan_if.channel chan,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    typedef enum logic [2:0] {
        CH_IDLE = 3'b000,
        CH_ADDR = 3'b001,
        CH_CMD = 3'b010,
        CH_STAT = 3'b011,
        CH_INT = 3'b100
    } cah_ch_t;
    cah_ch_t st_reg;
    logic [7:0] cmd_reg, stat_reg, addr_reg;
    logic [2:0] irq_reg, mask_reg;
    logic [2:0] tog_reg;
    logic aw_reg, w_reg, busy_uc_reg, done_ev, halt_req, go;
    logic [31:0] wdat_reg;

    // write channel capture, either order
    assign s_axi_awready = !aw_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_reg && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;
    assign s_axi_arready = !s_axi_rvalid;
    assign go = aw_reg && w_reg && addr_reg == `CAH_REG_CMD && st_reg == CH_IDLE;
    // halt toggle is a level, held until software clears it
    assign halt_req = tog_reg[0];
    assign done_ev = (st_reg == CH_STAT || st_reg == CH_INT) && chan.status_in;
    assign irq = |(irq_reg & mask_reg);

    // axi write path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdat_reg <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            cmd_reg <= 8'h00;
            mask_reg <= 3'b000;
            tog_reg <= 3'b000;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_reg <= 1'b1;
                addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_reg <= 1'b1;
                wdat_reg <= s_axi_wdata;
            end
            if (aw_reg && w_reg)
            begin
                aw_reg <= 1'b0;
                w_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (addr_reg == `CAH_REG_CMD && s_axi_wstrb[0])
                    cmd_reg <= wdat_reg[7:0];
                if (addr_reg == `CAH_REG_MASK)
                    mask_reg <= wdat_reg[2:0];
                if (addr_reg == `CAH_REG_TOGGLES)
                    tog_reg <= wdat_reg[2:0];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi read path; reading irq status clears it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            irq_reg <= 3'b000;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                unique case (s_axi_araddr)
                    `CAH_REG_CMD: s_axi_rdata <= {24'h00_0000, cmd_reg};
                    `CAH_REG_STAT: s_axi_rdata <= {23'h00_0000, busy_uc_reg, stat_reg};
                    `CAH_REG_IRQ: s_axi_rdata <= {29'h0000_0000, irq_reg};
                    `CAH_REG_MASK: s_axi_rdata <= {29'h0000_0000, mask_reg};
                    `CAH_REG_TOGGLES: s_axi_rdata <= {29'h0000_0000, tog_reg};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // set wins over read clear
            irq_reg <= ((s_axi_arvalid && s_axi_arready && s_axi_araddr == `CAH_REG_IRQ) ? 3'b000 : irq_reg)
                | {chan.request_in, halt_req, done_ev};
        end
    end

    // selection sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= CH_IDLE;
            stat_reg <= 8'h00;
            busy_uc_reg <= 1'b0;
        end
        else if (ce)
        begin
            unique case (st_reg)
                CH_IDLE:
                    // busy from unit word, no selection
                    if (go && wdat_reg[7:0] == `CAH_CMD_TIO && chan.operational_in)
                    begin
                        busy_uc_reg <= 1'b1;
                        stat_reg <= 8'h00;
                        stat_reg[`CAH_ST_BUSY] <= 1'b1;
                    end
                    else if (go)
                    begin
                        busy_uc_reg <= 1'b0;
                        st_reg <= CH_ADDR;
                    end
                    else if (chan.request_in)
                        st_reg <= CH_INT;
                // drop address-out once the unit answers with op-in
                CH_ADDR:
                    if (chan.operational_in)
                        st_reg <= CH_CMD;
                // command-out stands for the one cycle address-in is seen
                CH_CMD:
                    if (chan.address_in)
                        st_reg <= CH_STAT;
                CH_STAT, CH_INT:
                    if (chan.status_in)
                    begin
                        stat_reg <= chan.bus_in;
                        st_reg <= CH_IDLE;
                    end
                    else if (st_reg == CH_STAT && !chan.operational_in)
                        // halted unit left; its status comes by request-in
                        st_reg <= CH_IDLE;
                default:
                    st_reg <= CH_IDLE;
            endcase
        end
    end

    // tag drive; halt is address-out without select-out
    assign chan.address_out = st_reg == CH_ADDR || (halt_req && chan.operational_in);
    assign chan.select_out = st_reg == CH_ADDR || st_reg == CH_CMD || st_reg == CH_INT;
    assign chan.command_out = st_reg == CH_CMD && chan.address_in;
    assign chan.service_out = chan.status_in;
    assign chan.bus_out = (st_reg == CH_ADDR) ? `CAH_DEV_ADDR : cmd_reg;
    assign chan.operational_out = !tog_reg[1];
    assign chan.general_reset = tog_reg[2];
endmodule : cah_channel

/* File: rtl/cah_cmd_decode.sv */
// Purpose: classify a channel command byte
// Assumes: byte bit 0 is the vector msb
// Notes: purely combinational
`timescale 1ns/1ns
`include "cah_params.svh"
module cah_cmd_decode
    import cah_pkg::*;
(
    input wire logic [7:0] cmd_byte,
    output cah_pkg::cah_cmd_t cmd_class,
    output logic is_alarm
);
    // low bits pick control; test I/O needs the whole byte zero
    always_comb
    begin
        if ((cmd_byte & `CAH_CMD_CTRL_MASK) == `CAH_CMD_CTRL_VAL)
            cmd_class = CAH_CMD_CTRL;
        else if (cmd_byte == `CAH_CMD_TIO)
            cmd_class = CAH_CMD_TIO;
        else
            cmd_class = CAH_CMD_OTHER;
    end
    assign is_alarm = cmd_byte[`CAH_CMD_ALARM_BIT];
endmodule : cah_cmd_decode

/* File: tb/cah_sva.sv */
// Purpose: checks on the tag and bus lines between channel and adapter
// Assumes: one clock, synchronous active-low reset
// Notes: status bit n sits at index 7-n
`timescale 1ns/1ns
`include "cah_params.svh"
module cah_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] bus_out,
    input wire logic [7:0] bus_in,
    input wire logic address_out,
    input wire logic command_out,
    input wire logic service_out,
    input wire logic select_out,
    input wire logic operational_out,
    input wire logic general_reset,
    input wire logic status_in,
    input wire logic operational_in,
    input wire logic request_in
);
    logic [7:0] cmd_reg;
    logic halt;
    logic ctrl_now;
    logic is_ctrl;
    logic is_tio;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // last command byte offered on bus out
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cmd_reg <= `CAH_CMD_SENSE;
        else if (command_out)
            cmd_reg <= bus_out;
    end
    // command classes and the halt condition
    assign ctrl_now = command_out && ((bus_out & `CAH_CMD_CTRL_MASK) == `CAH_CMD_CTRL_VAL);
    assign is_ctrl = (cmd_reg & `CAH_CMD_CTRL_MASK) == `CAH_CMD_CTRL_VAL;
    assign is_tio = cmd_reg == `CAH_CMD_TIO;
    assign halt = address_out && !select_out && operational_in;
    ctrl_status_a: assert property (
        ctrl_now |-> ##[1:16] status_in) else $error("control command gave no status");
    ctrl_ends_a: assert property (
        status_in && is_ctrl && !bus_in[`CAH_ST_BUSY] |-> bus_in[`CAH_ST_CE] && bus_in[`CAH_ST_DE])
        else $error("control status lacks end bits");
    tio_nobusy_a: assert property (
        status_in && is_tio && (bus_in[`CAH_ST_ATTN] || bus_in[`CAH_ST_CE] || bus_in[`CAH_ST_DE])
        |-> !bus_in[`CAH_ST_BUSY]) else $error("busy shown with cleared conditions");
    status_drop_a: assert property (
        status_in && service_out |=> !status_in) else $error("status held after acceptance");
    halt_disc_a: assert property (
        halt |-> ##[1:4] !operational_in) else $error("halt did not disconnect");
    halt_req_a: assert property (
        halt |-> ##[1:16] request_in) else $error("no request after halt");
    sel_reset_a: assert property (
        $fell(operational_out) && operational_in |-> ##[1:4] !operational_in)
        else $error("selective reset ignored");
    gen_reset_a: assert property (
        general_reset ##1 general_reset |-> !operational_in && !status_in)
        else $error("general reset ignored");
endmodule : cah_sva

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the channel and adapter ends
// Assumes: both ends joined by one interface instance
// Notes: control bytes come from an lfsr with a fixed start
`timescale 1ns/1ns
`include "cah_params.svh"
module testbench;
    import cah_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic io_busy = 1'b0;
    logic attn_event = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, initial_reset, sense_clear, stop_reg;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [7:0] last_status_reg, c, st;
    logic [31:0] lfsr_reg = 32'h6872_9a19;
    logic halt_seen = 1'b0;
    logic stop_seen = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int stat_cnt = 0;
    int ir_cnt = 0;
    int sc_cnt = 0;
    int n0, ir0, sc0;
    cah_chan_if chan_bus();
    cah_channel cah_channel_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .chan(chan_bus),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    cah_adapter cah_adapter_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .chan(chan_bus),
        .io_busy(io_busy), .attn_event(attn_event), .initial_reset(initial_reset),
        .sense_clear(sense_clear), .stop_reg(stop_reg), .last_status_reg(last_status_reg));
    cah_sva cah_sva_inst (.aclk(aclk), .aresetn(aresetn), .bus_out(chan_bus.bus_out), .bus_in(chan_bus.bus_in),
        .address_out(chan_bus.address_out), .command_out(chan_bus.command_out),
        .service_out(chan_bus.service_out), .select_out(chan_bus.select_out),
        .operational_out(chan_bus.operational_out), .general_reset(chan_bus.general_reset),
        .status_in(chan_bus.status_in), .operational_in(chan_bus.operational_in),
        .request_in(chan_bus.request_in));
    // free-running clock
    always #5 aclk = ~aclk;
    // count status handshakes and adapter pulses; flag halts and stop
    always @(posedge aclk)
    begin
        if (chan_bus.status_in && chan_bus.service_out)
            stat_cnt <= stat_cnt + 1;
        if (initial_reset)
            ir_cnt <= ir_cnt + 1;
        if (sense_clear)
            sc_cnt <= sc_cnt + 1;
        if (chan_bus.address_out && !chan_bus.select_out && chan_bus.operational_in)
            halt_seen <= 1'b1;
        if (stop_reg)
            stop_seen <= 1'b1;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] ctrl_status();
        logic [7:0] s;
        s = 8'h00;
        s[`CAH_ST_CE] = 1'b1;
        s[`CAH_ST_DE] = 1'b1;
        return s;
    endfunction : ctrl_status
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            aw_done = aw_done | (awvalid & awready);
            w_done = w_done | (wvalid & wready);
            if (aw_done)
                awvalid <= 1'b0;
            if (w_done)
                wvalid <= 1'b0;
        end
        do
            @(posedge aclk);
        while (!bvalid);
        bready <= 1'b0;
        check_byte({6'h00, bresp}, 8'h00);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!rvalid);
        d = rdata;
        rready <= 1'b0;
        check_byte({6'h00, rresp}, 8'h00);
    endtask : axi_read
    // issue one command and wait for its status handshake
    task automatic run_cmd(input logic [7:0] cmd);
        n0 = stat_cnt;
        axi_write(`CAH_REG_CMD, {24'h00_0000, cmd});
        while (stat_cnt == n0)
            @(posedge aclk);
        repeat (2) @(posedge aclk);
        axi_read(`CAH_REG_STAT, rd);
        st = rd[7:0];
    endtask : run_cmd
    // watchdog against hangs
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        finish_test();
    end
    // main sequence
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_bit(irq, 1'b0);
        check_bit(stop_reg, 1'b0);
        check_byte(last_status_reg, 8'h00);
        $display("reset test done");
        // no-op, alarm, then random control bytes
        for (int i = 0; i < 8; i++)
        begin
            lfsr_reg = lfsr_next(lfsr_reg);
            c = {lfsr_reg[7:2], 2'b11};
            if (i < 2)
                c = 8'h03;
            if (i == 1)
                c[`CAH_CMD_ALARM_BIT] = 1'b1;
            ir0 = ir_cnt;
            sc0 = sc_cnt;
            run_cmd(c);
            check_byte(st, ctrl_status()); // ends in selection status
            check_byte(last_status_reg, ctrl_status()); // end bit positions
            check_bit(ir_cnt != ir0, c[`CAH_CMD_ALARM_BIT]); // reset only on alarm
            check_bit(sc_cnt != sc0, c[`CAH_CMD_ALARM_BIT]); // sense cleared only on alarm
        end
        $display("control test done");
        // attention lands on the edge that starts selection, busy pending
        io_busy <= 1'b1;
        fork
            run_cmd(`CAH_CMD_TIO);
            begin
                repeat (2) @(posedge aclk);
                attn_event <= 1'b1;
                @(posedge aclk);
                attn_event <= 1'b0;
            end
        join
        check_bit(st[`CAH_ST_ATTN], 1'b1); // attention reported
        check_bit(st[`CAH_ST_BUSY], 1'b0); // busy left out
        run_cmd(`CAH_CMD_TIO);
        check_bit(st[`CAH_ST_ATTN], 1'b0); // attention gone
        io_busy <= 1'b1;
        run_cmd(8'h03);
        check_bit(st[`CAH_ST_BUSY], 1'b1); // busy while executing
        $display("interrogation test done");
        axi_write(`CAH_REG_CMD, {24'h00_0000, `CAH_CMD_SENSE});
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0001);
        for (int k = 0; k < 40 && !chan_bus.request_in; k++)
            @(posedge aclk);
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0000);
        io_busy <= 1'b0;
        check_bit(halt_seen, 1'b1); // halt condition formed
        check_bit(stop_seen, 1'b1); // stop set by halt
        axi_read(`CAH_REG_IRQ, rd);
        check_bit(rd[2], 1'b1); // request-in after halt
        $display("halt test done");
        axi_write(`CAH_REG_MASK, 32'h0000_0000);
        run_cmd(8'h03);
        check_bit(irq, 1'b0);
        axi_read(`CAH_REG_IRQ, rd);
        check_bit(rd[0], 1'b1);
        axi_write(`CAH_REG_MASK, 32'h0000_0007);
        run_cmd(8'h03);
        check_bit(irq, 1'b1);
        axi_read(`CAH_REG_IRQ, rd);
        @(posedge aclk);
        check_bit(irq, 1'b0);
        axi_read(8'h20, rd);
        check_byte(rd[7:0], 8'h00);
        $display("interrupt test done");
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0002);
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0000);
        check_bit(chan_bus.operational_in, 1'b0); // no unit connected, operational-in stays low
        check_bit(stop_reg, 1'b1); // idle unit keeps its stop
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0004);
        axi_write(`CAH_REG_TOGGLES, 32'h0000_0000);
        check_bit(stop_reg, 1'b0); // general reset clears stop
        run_cmd(8'h03);
        check_byte(st, ctrl_status()); // no-op still completes
        $display("reset lines test done");
        finish_test();
    end
endmodule : testbench
